//--- core/sideband_regs.svh
/*
 * constants for the processor sideband block: widths, sync depth, global reset warning timing.
 * assumes inclusion by bare name from core/ files.
 */
`ifndef SIDEBAND_REGS_SVH
`define SIDEBAND_REGS_SVH

`define THERMAL_INPUT_COUNT 4
`define SYNC_STAGES         2
`define SYNC_STAGE_BITS     2
`define GRST_WARN_NS        1000
`define CLK_PERIOD_NS       50
`define GRST_WARN_CYCLES    ((`GRST_WARN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WARN_COUNT_BITS     5

`endif

//--- core/sideband_pkg.sv
/*
 * types for the processor sideband block.
 * assumes sideband_regs.svh is included before use.
 */
`include "sideband_regs.svh"

package sideband_pkg;

    typedef enum logic [1:0] {
        PWR_ON,
        PWR_GRST_WARN,
        PWR_SOFT_OFF
    } power_state_type;

    typedef struct packed {
        logic                             thermal_trip_n;
        logic                             pm_state_from_cpu;
        logic [`THERMAL_INPUT_COUNT-1:0]  cpu_thermal_inputs;
    } cpu_inputs_type;

    typedef struct packed {
        logic cpu_power_good_o;
        logic cpu_power_good_oe;
        logic cpu_platform_reset_n;
        logic pm_state_to_cpu;
    } cpu_outputs_type;

endpackage : sideband_pkg

//--- core/level_sync.sv
/*
 * two-flop synchroniser for one level.
 * assumes input is asynchronous to clk_sys.
 */
`timescale 1ns/1ps
`include "sideband_regs.svh"

module level_sync #(
    parameter logic RESET_VALUE = 1'b0
) (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic clk_en,
    // level
    input  wire logic din,
    output logic      dout
);
    logic [`SYNC_STAGES-1:0] stage_q;
    logic [`SYNC_STAGES-1:0] stage_d;

    always_comb begin
        stage_d = {stage_q[`SYNC_STAGES-2:0], din};
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            stage_q <= {`SYNC_STAGES{RESET_VALUE}};
        end else if (clk_en) begin
            stage_q <= stage_d;
        end
    end

    assign dout = stage_q[`SYNC_STAGES-1];
endmodule : level_sync

//--- core/processor_sideband_control.sv
/*
 * processor sideband control: power good, platform reset, pm_state_to_cpu out,
 * thermal trip to soft-off, wake from processor, thermal wire and inputs.
 * assumes rst_n is the resume-well reset, synchronous to clk_sys.
 */
`timescale 1ns/1ps
`include "sideband_regs.svh"

// Overview of operation
// - power good undriven during resume-well reset and in soft-off, driven high otherwise
// - active thermal trip moves platform to soft-off once it has passed the two-flop input synchroniser
// - sync line gives processor early warning of global reset
// - incoming pm line from processor is a wake event
// - sync line low during and right after reset
// - platform reset low in reset, high after, off in sleep states
// - resume-well reset is the reference for all these pins
// - four thermal inputs accepted, never driven
// - thermal wire shared, left undriven during and after reset
module processor_sideband_control (
    // clock, reset, enable
    input  wire logic                             clk_sys,
    input  wire logic                             rst_n,
    input  wire logic                             clk_en,
    // global reset request from platform logic
    input  wire logic                             global_reset_req,
    // pins from processor
    input  wire sideband_pkg::cpu_inputs_type     cpu_in,
    // thermal wire
    input  wire logic                             cpu_thermal_wire_i,
    output logic                                  cpu_thermal_wire_o,
    output logic                                  cpu_thermal_wire_oe,
    // pins to processor
    output sideband_pkg::cpu_outputs_type         cpu_out,
    // platform power side
    output logic                                  soft_off_req,
    output logic                                  wake_event,
    output logic                                  global_reset_go,
    output logic [`THERMAL_INPUT_COUNT-1:0]       thermal_status,
    output logic                                  thermal_wire_level
);
    logic                           trip_n_s;
    logic                           pm_in_s;
    logic                           pm_in_prev_q;
    logic                           pm_in_prev_d;
    sideband_pkg::power_state_type  state_q;
    sideband_pkg::power_state_type  state_d;
    logic [`WARN_COUNT_BITS-1:0]    warn_cnt_q;
    logic [`WARN_COUNT_BITS-1:0]    warn_cnt_d;
    logic                           released_q;
    logic [`THERMAL_INPUT_COUNT-1:0] therm_q;
    logic                           wire_q;

    // input synchronisers
    level_sync #(.RESET_VALUE(1'b1)) u_trip_sync (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .clk_en  (clk_en),
        .din     (cpu_in.thermal_trip_n),
        .dout    (trip_n_s)
    );

    level_sync #(.RESET_VALUE(1'b0)) u_pm_state_to_cpu (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .clk_en  (clk_en),
        .din     (cpu_in.pm_state_from_cpu),
        .dout    (pm_in_s)
    );

    // power state and warning counter
    always_comb begin
        state_d      = state_q;
        warn_cnt_d   = warn_cnt_q;
        pm_in_prev_d = pm_in_s;
        unique case (state_q)
            sideband_pkg::PWR_ON: begin
                if (!trip_n_s) begin
                    state_d = sideband_pkg::PWR_SOFT_OFF;
                end else if (global_reset_req) begin
                    state_d    = sideband_pkg::PWR_GRST_WARN;
                    warn_cnt_d = '0;
                end
            end
            sideband_pkg::PWR_GRST_WARN: begin
                if (!trip_n_s) begin
                    state_d = sideband_pkg::PWR_SOFT_OFF;
                end else if (warn_cnt_q == `WARN_COUNT_BITS'(`GRST_WARN_CYCLES - 1)) begin
                    state_d = sideband_pkg::PWR_ON;
                end else begin
                    warn_cnt_d = warn_cnt_q + `WARN_COUNT_BITS'(1);
                end
            end
            sideband_pkg::PWR_SOFT_OFF: begin
                if (pm_in_s && !pm_in_prev_q && trip_n_s) begin
                    state_d = sideband_pkg::PWR_ON;
                end
            end
            // unused code falls back to the on state
            default: begin
                state_d = sideband_pkg::PWR_ON;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_q      <= sideband_pkg::PWR_ON;
            warn_cnt_q   <= '0;
            pm_in_prev_q <= 1'b0;
            released_q   <= 1'b0;
        end else if (clk_en) begin
            state_q      <= state_d;
            warn_cnt_q   <= warn_cnt_d;
            pm_in_prev_q <= pm_in_prev_d;
            released_q   <= 1'b1;
        end
    end

    // thermal inputs and wire sampled only
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            therm_q <= '0;
            wire_q  <= 1'b0;
        end else if (clk_en) begin
            therm_q <= cpu_in.cpu_thermal_inputs;
            wire_q  <= cpu_thermal_wire_i;
        end
    end

    // pin drive
    always_comb begin
        cpu_out.cpu_power_good_o  = 1'b1;
        cpu_out.cpu_power_good_oe = released_q
            && (state_q != sideband_pkg::PWR_SOFT_OFF);
        cpu_out.cpu_platform_reset_n = released_q
            && (state_q != sideband_pkg::PWR_SOFT_OFF);
        cpu_out.pm_state_to_cpu = released_q
            && (state_q == sideband_pkg::PWR_GRST_WARN);
    end

    assign cpu_thermal_wire_o  = 1'b0;
    assign cpu_thermal_wire_oe = 1'b0;
    assign soft_off_req        = (state_q == sideband_pkg::PWR_SOFT_OFF);
    assign wake_event          = (state_q == sideband_pkg::PWR_SOFT_OFF)
                                 && pm_in_s && !pm_in_prev_q && trip_n_s;
    assign global_reset_go     = (state_q == sideband_pkg::PWR_GRST_WARN)
        && (warn_cnt_q == `WARN_COUNT_BITS'(`GRST_WARN_CYCLES - 1));
    assign thermal_status      = therm_q;
    assign thermal_wire_level  = wire_q;
endmodule : processor_sideband_control

//--- verif/sideband_asserts.sv
/* assertions on processor_sideband_control ports.
   assumes clk_en held high by the bench. */
`timescale 1ns/1ps
module sideband_asserts (
    // clock, reset
    input wire logic                          clk_sys,
    input wire logic                          rst_n,
    // inputs
    input wire logic                          global_reset_req,
    input wire sideband_pkg::cpu_inputs_type  cpu_in,
    // outputs
    input wire logic                          cpu_thermal_wire_oe,
    input wire sideband_pkg::cpu_outputs_type cpu_out,
    input wire logic                          soft_off_req,
    input wire logic                          wake_event,
    input wire logic                          global_reset_go
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    wire_free_a: assert property (!cpu_thermal_wire_oe) else $error("wire driven");
    trip_sync_a: assert property (
        $fell(cpu_in.thermal_trip_n) && !soft_off_req |=> !soft_off_req) else $error("trip early");
    trip_off_a: assert property (
        $fell(cpu_in.thermal_trip_n) |-> ##[2:4] soft_off_req) else $error("no soft off");
    off_pins_a: assert property (soft_off_req |-> cpu_out[2:0] == 3'h0) else $error("pins on");
    warn_len_a: assert property ($rose(cpu_out.pm_state_to_cpu) |->
        (cpu_out.pm_state_to_cpu && !global_reset_go) [*8] ##12
        (cpu_out.pm_state_to_cpu && global_reset_go) ##1 !cpu_out.pm_state_to_cpu)
        else $error("warning length");
    warn_start_a: assert property (
        global_reset_req && !cpu_out.pm_state_to_cpu && !soft_off_req |=> cpu_out.pm_state_to_cpu)
        else $error("warning not started");
    wake_a: assert property (
        wake_event |-> soft_off_req ##1 !(wake_event || soft_off_req)) else $error("bad wake");
    pg_on_a: assert property (
        !soft_off_req && !$past(soft_off_req) && $past(rst_n) |-> cpu_out[3:1] == 3'h7)
        else $error("pins not on");
    sync_low_a: assert property (
        $rose(rst_n) |-> !(cpu_out.pm_state_to_cpu || global_reset_go)) else $error("sync high");
    cover property ($rose(soft_off_req));
    cover property (wake_event);
    cover property (global_reset_go);
endmodule : sideband_asserts

bind processor_sideband_control sideband_asserts i_sideband_asserts (
    .clk_sys(clk_sys), .rst_n(rst_n), .global_reset_req(global_reset_req), .cpu_in(cpu_in),
    .cpu_thermal_wire_oe(cpu_thermal_wire_oe), .cpu_out(cpu_out), .soft_off_req(soft_off_req),
    .wake_event(wake_event), .global_reset_go(global_reset_go));

//--- verif/cpu_side_model.sv
/* processor side of the sideband pins.
   assumes the bench resolves the thermal wire. */
`timescale 1ns/1ps
module cpu_side_model (
    // clock
    input  wire logic                   clk_sys,
    // commands
    input  wire logic                   trip,
    input  wire logic                   wake,
    input  wire logic [3:0]             therm,
    // pins
    output sideband_pkg::cpu_inputs_type pins,
    output logic                        wire_drv
);
    assign pins = {~trip, wake, therm};
    initial wire_drv = 1'h0;
    always @(negedge clk_sys) wire_drv <= ~wire_drv;
endmodule : cpu_side_model

//--- verif/tb_top.sv
/* self-checking bench for processor_sideband_control.
   assumes checker bound from its own file. */
`timescale 1ns/1ps
module tb_top;
    logic                          clk_sys, rst_n, req, trip, wake, wire_drv, wire_i;
    logic                          wire_o, wire_oe, soft_off, wake_ev, go, wire_lvl;
    logic [3:0]                    therm, status;
    logic [7:0]                    n, g;
    sideband_pkg::cpu_inputs_type  pins;
    sideband_pkg::cpu_outputs_type outs;
    int                            failures, n_tests;
    cpu_side_model i_cpu_side_model (.clk_sys(clk_sys), .trip(trip), .wake(wake),
        .therm(therm), .pins(pins), .wire_drv(wire_drv));
    processor_sideband_control i_processor_sideband_control (.clk_sys(clk_sys),
        .rst_n(rst_n), .clk_en(1'h1), .global_reset_req(req), .cpu_in(pins),
        .cpu_thermal_wire_i(wire_i), .cpu_thermal_wire_o(wire_o), .cpu_thermal_wire_oe(wire_oe),
        .cpu_out(outs), .soft_off_req(soft_off), .wake_event(wake_ev), .global_reset_go(go),
        .thermal_status(status), .thermal_wire_level(wire_lvl));
    assign wire_i = wire_oe ? wire_o : wire_drv;
    function automatic logic [3:0] exp_pins(input logic on);
        return {1'h1, on, on, 1'h0};
    endfunction : exp_pins
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : stop_test
    task automatic trip_wake();
        trip = 1'h1;
        repeat (4) @(negedge clk_sys);
        check({soft_off, outs}, 5'h18);
        req = 1'h1;
        wake = 1'h1;
        repeat (4) @(negedge clk_sys);
        check({soft_off, outs.pm_state_to_cpu, wake_ev}, 3'h4);
        {req, wake, trip} = '0;
        repeat (3 + $urandom_range(5)) @(negedge clk_sys);
        wake = 1'h1;
        n = '0;
        repeat (6) begin
            @(negedge clk_sys);
            n += wake_ev;
        end
        check({n[3:0], soft_off, outs}, {4'h1, 1'h0, exp_pins(1'h1)});
        wake = 1'h0;
        $display("trip and wake done");
    endtask : trip_wake
    initial begin
        clk_sys = 1'h0;
        forever #25 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (2000) @(posedge clk_sys);
        failures++;
        stop_test();
    end
    initial begin
        void'($urandom(32'h7126));
        {rst_n, req, trip, wake, therm, failures, n_tests} = '0;
        repeat (8) @(negedge clk_sys);
        check({wire_oe, outs}, exp_pins(1'h0));
        rst_n = 1'h1;
        repeat (2) @(negedge clk_sys);
        check(outs, exp_pins(1'h1));
        repeat (8) begin
            therm = 4'($urandom());
            repeat (3) @(negedge clk_sys);
            check({status, wire_lvl, wire_oe}, {therm, wire_i, 1'h0});
        end
        req = 1'h1;
        {n, g} = '0;
        for (int i = 0; i < 40; i++) begin
            @(negedge clk_sys);
            req = (i == 6);
            n += outs.pm_state_to_cpu;
            g += go;
        end
        check({n, g}, {8'(`GRST_WARN_CYCLES), 8'h01});
        $display("reset, inputs and warning done");
        trip_wake();
        trip_wake();
        stop_test();
    end
endmodule : tb_top
